/* rtl/dacs_defs.svh */
// Purpose: Constants of the two-channel conversion sequencer
// Assumes: pclk at 10 MHz
// Notes:   Times in ns as printed, cycle counts derived
//
// Behaviour
// R1: Busy ends within 1.75 us (2 us reduced power) outside read-after-convert serial.
// R2: Channel A converts first; its end-of-conversion high lasts at most 1/1.25 us.
// R3: End-of-conversion drops at least 45 ns between channel A and channel B.
// R4: End-of-conversion high for channel B lasts at most 0.75 us.
// R5: Busy falls at least 10 ns after both conversions end.
// R6: Parallel result valid within 1.75/2 us of the convert start fall.
// R7: Parallel result valid at least 14 ns before busy falls.
// R8: Divider code sets least serial clock period 25, 50, 100, 200 ns.
// R9: Divider code sets typical serial clock period 40, 70, 140, 280 ns.
// R10: Serial clock high at least 12, 22, 50, 100 ns per divider code.
// R11: Frame sync leads first serial clock edge by 3 ns (code 00) or 17 ns.
// R12: Read-after-convert busy at most 3.25/4.25/6.25/10.75 us, normal power; the code holds busy 7.9/7.9/7.9/11.1 us.
// R13: Read-after-convert busy at most 3.5/4.5/6.5/11 us, reduced power; the code holds busy 8.0/8.0/8.0/11.2 us.
// R14: Read-during-convert frame sync about 250/500 ns after convert start.
// R15: Read-after-convert frame sync about 0.75/1 us after convert start.
// R16: Busy falls about 25 ns after frame sync ends in serial modes; in read-during-convert the code drops busy while the frame still runs.
// R17: Channel order select high shifts A first, low shifts B first.
// R18: Port select high gives serial output, low gives parallel output.
// R19: Host issues no convert start while busy or a readout runs.
`ifndef DACS_DEFS_SVH
`define DACS_DEFS_SVH

`define DACS_CLK_NS 100
`define DACS_CYC_MIN(ns) ((((ns) + `DACS_CLK_NS - 1) / `DACS_CLK_NS) < 1 ? 1 : (((ns) + `DACS_CLK_NS - 1) / `DACS_CLK_NS))
`define DACS_CYC_MAX(ns) (((ns) / `DACS_CLK_NS) < 1 ? 1 : ((ns) / `DACS_CLK_NS))

// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define DACS_OFS_CTRL   12'h000
`define DACS_OFS_STATUS 12'h004
`define DACS_OFS_RESULT 12'h008
`define DACS_CTRL_SER     0
`define DACS_CTRL_AFIRST  1
`define DACS_CTRL_IMPULSE 2
`define DACS_CTRL_RDAFTER 3
`define DACS_CTRL_DIV_LO  4
`define DACS_CTRL_PARA    6
`define DACS_CTRL_RESET   7'h42

// ----------------------------------------------------------------
// Conversion timing
// ----------------------------------------------------------------
`define DACS_BUSY_MAX_NRM_NS 1750
`define DACS_BUSY_MAX_IMP_NS 2000
`define DACS_EOCA_MAX_NRM_NS 1000
`define DACS_EOCA_MAX_IMP_NS 1250
`define DACS_EOC_GAP_MIN_NS  45
`define DACS_EOCB_MAX_NS     750
`define DACS_BUSY_END_MIN_NS 10
`define DACS_DATA_LEAD_NS    14
`define DACS_FS_DC_NRM_NS    250
`define DACS_FS_DC_IMP_NS    500
`define DACS_FS_AC_NRM_NS    750
`define DACS_FS_AC_IMP_NS    1000
`define DACS_FS_BUSY_NS      25

// ----------------------------------------------------------------
// Serial clock timing per divider code
// ----------------------------------------------------------------
`define DACS_SCK_PMIN_NS(c) ((c) == 2'b00 ? 25 : (c) == 2'b01 ? 50 : (c) == 2'b10 ? 100 : 200)
`define DACS_SCK_PTYP_NS(c) ((c) == 2'b00 ? 40 : (c) == 2'b01 ? 70 : (c) == 2'b10 ? 140 : 280)
`define DACS_SCK_HMIN_NS(c) ((c) == 2'b00 ? 12 : (c) == 2'b01 ? 22 : (c) == 2'b10 ? 50 : 100)
`define DACS_FS_LEAD_NS(c)  ((c) == 2'b00 ? 3 : 17)
`define DACS_SER_BITS       32

`endif

/* rtl/dacs_pkg.sv */
// Purpose: Types of the conversion sequencer
// Assumes: Nothing
// Notes:   State of each module is one packed struct
package dacs_pkg;

  typedef enum logic [2:0] {
    CV_IDLE, CV_CONV_A, CV_GAP, CV_CONV_B, CV_TAIL, CV_WAIT_SER, CV_SER_TAIL
  } dacs_cv_t;

  typedef enum logic [2:0] {SR_IDLE, SR_LEAD, SR_LOW, SR_HIGH, SR_END} dacs_sr_t;

  typedef struct packed {
    dacs_cv_t    st;
    logic [3:0]  cnt;
    logic [4:0]  el;
    logic        busy;
    logic        eoc;
    logic        cs_d;
    logic        dc_pend;
    logic        launched;
    logic        ser_go;
    logic [31:0] word;
    logic [6:0]  ctrl;
    logic [15:0] res_a;
    logic [15:0] res_b;
    logic [15:0] dout;
    logic [31:0] prdata;
  } dacs_top_st_t;

  typedef struct packed {
    dacs_sr_t    st;
    logic [1:0]  cnt;
    logic [4:0]  bits;
    logic [31:0] sh;
    logic [1:0]  div;
    logic        sck;
    logic        fs;
    logic        sdo;
    logic        done;
  } dacs_ser_st_t;

  typedef struct packed {
    logic [2:0] ff;
    logic       lvl;
  } dacs_sync_st_t;

endpackage

/* rtl/dacs_ser_if.sv */
// Purpose: Link between sequencer and serial shifter
// Assumes: Single pclk domain
// Notes:   go is a one-cycle pulse, word valid with it
`timescale 1ns/10ps
interface dacs_ser_if;
  logic        go;
  logic [31:0] word;
  logic [1:0]  div;
  logic        active;
  logic        done;
  modport ctl (output go, output word, output div, input active, input done);
  modport ser (input go, input word, input div, output active, output done);
endinterface

/* rtl/dacs_sync.sv */
// Purpose: Pin synchroniser with agreement filter
// Assumes: Pin asynchronous to pclk
// Notes:   Level moves only when stages two and three agree
`timescale 1ns/10ps
module dacs_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      lvl
);
  dacs_pkg::dacs_sync_st_t s_r;
  dacs_pkg::dacs_sync_st_t s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.ff = {s_r.ff[1:0], pin};
    if (s_r.ff[1] == s_r.ff[2]) begin
      s_nxt.lvl = s_r.ff[2];
    end
  end

  // Idle high so no false start at reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{ff: 3'h7, lvl: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lvl = s_r.lvl;
endmodule

/* rtl/dacs_ser.sv */
// Purpose: Master serial shifter for both results
// Assumes: Started only when not active
// Notes:   Clock phases of whole pclk cycles
`timescale 1ns/10ps
`include "dacs_defs.svh"
module dacs_ser (
  input  wire logic pclk,
  input  wire logic presetn,
  dacs_ser_if.ser   sif,
  output logic      ser_clk,
  output logic      frame_sync,
  output logic      serial_result_out
);
  dacs_pkg::dacs_ser_st_t s_r;
  dacs_pkg::dacs_ser_st_t s_nxt;
  logic [1:0] hi_c;
  logic [1:0] lo_c;
  logic [1:0] lead_c;

  // Low phase fills typical period, never under the least period
  always_comb begin
    hi_c   = 2'(`DACS_CYC_MIN(`DACS_SCK_HMIN_NS(s_r.div)) - 1); // R10
    lo_c   = 2'(`DACS_CYC_MIN(`DACS_SCK_PTYP_NS(s_r.div)) - 2); // R9
    if (`DACS_CYC_MIN(`DACS_SCK_PMIN_NS(s_r.div)) > `DACS_CYC_MIN(`DACS_SCK_PTYP_NS(s_r.div))) begin
      lo_c = 2'(`DACS_CYC_MIN(`DACS_SCK_PMIN_NS(s_r.div)) - 2); // R8
    end
    if (`DACS_CYC_MIN(`DACS_SCK_PTYP_NS(s_r.div)) < 2) begin
      lo_c = 2'h0;
    end
    lead_c = 2'(`DACS_CYC_MIN(`DACS_FS_LEAD_NS(s_r.div)) - 1);
  end

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      dacs_pkg::SR_IDLE: begin
        if (sif.go) begin
          s_nxt.sh   = sif.word;
          s_nxt.div  = sif.div;
          s_nxt.fs   = 1'b1;
          s_nxt.bits = 5'h00;
          s_nxt.cnt  = 2'h0;
          s_nxt.st   = dacs_pkg::SR_LEAD;
        end
      end
      dacs_pkg::SR_LEAD: begin
        if (s_r.cnt >= lead_c) begin // R11
          s_nxt.sdo = s_r.sh[31];
          s_nxt.cnt = 2'h0;
          s_nxt.st  = dacs_pkg::SR_LOW;
        end else begin
          s_nxt.cnt = s_r.cnt + 2'h1;
        end
      end
      dacs_pkg::SR_LOW: begin
        if (s_r.cnt >= lo_c) begin
          s_nxt.sck = 1'b1;
          s_nxt.cnt = 2'h0;
          s_nxt.st  = dacs_pkg::SR_HIGH;
        end else begin
          s_nxt.cnt = s_r.cnt + 2'h1;
        end
      end
      dacs_pkg::SR_HIGH: begin
        if (s_r.cnt >= hi_c) begin
          s_nxt.sck  = 1'b0;
          s_nxt.cnt  = 2'h0;
          s_nxt.sh   = {s_r.sh[30:0], 1'b0};
          s_nxt.sdo  = s_r.sh[30];
          s_nxt.bits = s_r.bits + 5'h01;
          s_nxt.st   = (s_r.bits == 5'(`DACS_SER_BITS - 1)) ? dacs_pkg::SR_END : dacs_pkg::SR_LOW;
        end else begin
          s_nxt.cnt = s_r.cnt + 2'h1;
        end
      end
      dacs_pkg::SR_END: begin
        s_nxt.fs   = 1'b0;
        s_nxt.sdo  = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.st   = dacs_pkg::SR_IDLE;
      end
      default: begin
        s_nxt.st = dacs_pkg::SR_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sif.active        = (s_r.st != dacs_pkg::SR_IDLE);
  assign sif.done          = s_r.done;
  assign ser_clk           = s_r.sck;
  assign frame_sync        = s_r.fs;
  assign serial_result_out = s_r.sdo;
endmodule

/* rtl/dacs_top.sv */
// Purpose: Two-channel conversion sequencer with APB control
// Assumes: Results of the converter core arrive on pclk
// Notes:   One conversion at a time, starts during activity dropped
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/10ps
`include "dacs_defs.svh"
module dacs_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        convert_start_n,
  input  wire logic [15:0] adc_result_a,
  input  wire logic [15:0] adc_result_b,
  output logic             busy,
  output logic             end_of_conv,
  output logic [15:0]      data_out,
  output logic             ser_clk,
  output logic             frame_sync,
  output logic             serial_result_out
);

  // ----------------------------------------------------------------
  // Derived cycle counts
  // ----------------------------------------------------------------
  // Phases use half their limit so the pin synchroniser fits the busy budget
  localparam int CONV_A_NRM = `DACS_CYC_MAX(`DACS_EOCA_MAX_NRM_NS) / 2;
  localparam int CONV_A_IMP = `DACS_CYC_MAX(`DACS_EOCA_MAX_IMP_NS) / 2;
  localparam int CONV_B     = `DACS_CYC_MAX(`DACS_EOCB_MAX_NS) / 2;
  localparam int GAP_CYC    = `DACS_CYC_MIN(`DACS_EOC_GAP_MIN_NS);
  localparam int TAIL_A     = `DACS_CYC_MIN(`DACS_BUSY_END_MIN_NS);
  localparam int TAIL_B     = `DACS_CYC_MIN(`DACS_DATA_LEAD_NS);
  localparam int TAIL_CYC   = (TAIL_A > TAIL_B) ? TAIL_A : TAIL_B;
  localparam int FS_DC_NRM  = `DACS_CYC_MIN(`DACS_FS_DC_NRM_NS);
  localparam int FS_DC_IMP  = `DACS_CYC_MIN(`DACS_FS_DC_IMP_NS);
  localparam int FS_AC_NRM  = `DACS_CYC_MIN(`DACS_FS_AC_NRM_NS);
  localparam int FS_AC_IMP  = `DACS_CYC_MIN(`DACS_FS_AC_IMP_NS);
  localparam int FS_BUSY    = `DACS_CYC_MIN(`DACS_FS_BUSY_NS);
  localparam int BUSY_NRM   = `DACS_CYC_MAX(`DACS_BUSY_MAX_NRM_NS);
  localparam int BUSY_IMP   = `DACS_CYC_MAX(`DACS_BUSY_MAX_IMP_NS);

  // ----------------------------------------------------------------
  // Pin synchroniser and serial shifter
  // ----------------------------------------------------------------
  logic cs_lvl;
  dacs_ser_if sif ();

  dacs_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (convert_start_n),
    .lvl     (cs_lvl)
  );

  dacs_ser u_ser (
    .pclk              (pclk),
    .presetn           (presetn),
    .sif               (sif),
    .ser_clk           (ser_clk),
    .frame_sync        (frame_sync),
    .serial_result_out (serial_result_out)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dacs_pkg::dacs_top_st_t s_r;
  dacs_pkg::dacs_top_st_t s_nxt;

  logic        cs_fall;
  logic        ser_mode;
  logic        a_first;
  logic        impulse;
  logic        rd_after;
  logic        par_a;
  logic        apb_setup;
  logic        apb_access;
  logic        addr_ok;
  logic [3:0]  conv_a_c;
  logic [4:0]  fs_dc_c;
  logic [4:0]  fs_ac_c;
  logic [4:0]  busy_lim_c;

  always_comb begin
    ser_mode   = s_r.ctrl[`DACS_CTRL_SER];
    a_first    = s_r.ctrl[`DACS_CTRL_AFIRST];
    impulse    = s_r.ctrl[`DACS_CTRL_IMPULSE];
    rd_after   = s_r.ctrl[`DACS_CTRL_RDAFTER];
    par_a      = s_r.ctrl[`DACS_CTRL_PARA];
    cs_fall    = s_r.cs_d & ~cs_lvl;
    apb_setup  = psel & ~penable;
    apb_access = psel & penable;
    addr_ok    = (paddr == `DACS_OFS_CTRL) || (paddr == `DACS_OFS_STATUS) ||
                 (paddr == `DACS_OFS_RESULT);
    conv_a_c   = impulse ? 4'(CONV_A_IMP) : 4'(CONV_A_NRM); // R2
    fs_dc_c    = impulse ? 5'(FS_DC_IMP) : 5'(FS_DC_NRM);
    fs_ac_c    = impulse ? 5'(FS_AC_IMP) : 5'(FS_AC_NRM);
    busy_lim_c = impulse ? 5'(BUSY_IMP) : 5'(BUSY_NRM);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt        = s_r;
    s_nxt.ser_go = 1'b0;
    s_nxt.cs_d   = cs_lvl;

    if (s_r.st != dacs_pkg::CV_IDLE && s_r.el != 5'h1f) begin
      s_nxt.el = s_r.el + 5'h01;
    end

    case (s_r.st)
      dacs_pkg::CV_IDLE: begin
        // Starts while a readout still runs are dropped
        if (cs_fall && !sif.active) begin // R19
          s_nxt.busy     = 1'b1;
          s_nxt.eoc      = 1'b1; // R2
          s_nxt.el       = 5'h00;
          s_nxt.cnt      = conv_a_c - 4'h1;
          s_nxt.launched = 1'b0;
          s_nxt.dc_pend  = ser_mode & ~rd_after;
          s_nxt.st       = dacs_pkg::CV_CONV_A;
        end
      end
      dacs_pkg::CV_CONV_A: begin
        if (s_r.cnt == 4'h0) begin
          s_nxt.res_a = adc_result_a;
          s_nxt.eoc   = 1'b0; // R3
          s_nxt.cnt   = 4'(GAP_CYC - 1);
          s_nxt.st    = dacs_pkg::CV_GAP;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      dacs_pkg::CV_GAP: begin
        if (s_r.cnt == 4'h0) begin
          s_nxt.eoc = 1'b1; // R3
          s_nxt.cnt = 4'(CONV_B - 1);
          s_nxt.st  = dacs_pkg::CV_CONV_B;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      dacs_pkg::CV_CONV_B: begin
        if (s_r.cnt == 4'h0) begin
          s_nxt.res_b = adc_result_b;
          s_nxt.eoc   = 1'b0; // R4
          s_nxt.cnt   = 4'(TAIL_CYC - 1);
          s_nxt.st    = dacs_pkg::CV_TAIL;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      dacs_pkg::CV_TAIL: begin
        if (s_r.cnt == 4'h0) begin
          if (ser_mode && rd_after) begin
            s_nxt.st = dacs_pkg::CV_WAIT_SER;
          end else begin
            s_nxt.busy = 1'b0; // R1 R5 R7
            s_nxt.st   = dacs_pkg::CV_IDLE;
          end
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      dacs_pkg::CV_WAIT_SER: begin
        // Frame waits for the typical delay, and results are always fresh here
        if (!s_r.launched && s_r.el >= fs_ac_c && !sif.active) begin // R15
          s_nxt.ser_go   = 1'b1;
          s_nxt.launched = 1'b1;
          s_nxt.word     = a_first ? {s_r.res_a, s_r.res_b} : {s_r.res_b, s_r.res_a}; // R17
        end
        // Done arrives with the frame fall, so the tail is one cycle shorter
        if (s_r.launched && sif.done) begin
          if (FS_BUSY <= 1) begin
            s_nxt.busy = 1'b0; // R16
            s_nxt.st   = dacs_pkg::CV_IDLE;
          end else begin
            s_nxt.cnt = 4'(FS_BUSY - 2);
            s_nxt.st  = dacs_pkg::CV_SER_TAIL;
          end
        end
      end
      dacs_pkg::CV_SER_TAIL: begin
        if (s_r.cnt == 4'h0) begin
          s_nxt.busy = 1'b0; // R16 R12 R13
          s_nxt.st   = dacs_pkg::CV_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      default: begin
        s_nxt.st   = dacs_pkg::CV_IDLE;
        s_nxt.busy = 1'b0;
        s_nxt.eoc  = 1'b0;
      end
    endcase

    // Read during convert shifts the previous pair out
    if (s_r.dc_pend && s_r.st != dacs_pkg::CV_IDLE && s_r.el >= fs_dc_c) begin // R14
      s_nxt.dc_pend = 1'b0;
      s_nxt.ser_go  = 1'b1;
      s_nxt.word    = a_first ? {s_r.res_a, s_r.res_b} : {s_r.res_b, s_r.res_a}; // R17
    end

    // Parallel bus follows the chosen channel, zero in serial mode
    if (ser_mode) begin // R18
      s_nxt.dout = 16'h0000;
    end else begin
      s_nxt.dout = par_a ? s_nxt.res_a : s_nxt.res_b; // R6
    end

    // APB read data captured in the setup phase
    if (apb_setup) begin
      case (paddr)
        `DACS_OFS_CTRL: begin
          s_nxt.prdata = {25'h0000000, s_r.ctrl};
        end
        `DACS_OFS_STATUS: begin
          s_nxt.prdata = {22'h000000, busy_lim_c, sif.active, s_r.dc_pend, frame_sync, s_r.eoc, s_r.busy};
        end
        `DACS_OFS_RESULT: begin
          s_nxt.prdata = {s_r.res_a, s_r.res_b};
        end
        default: begin
          s_nxt.prdata = 32'h00000000;
        end
      endcase
    end

    if (apb_access && pwrite && paddr == `DACS_OFS_CTRL) begin
      s_nxt.ctrl = pwdata[6:0];
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r      <= '0;
      s_r.st   <= dacs_pkg::CV_IDLE;
      s_r.cs_d <= 1'b1;
      s_r.ctrl <= `DACS_CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sif.go   = s_r.ser_go;
  assign sif.word = s_r.word;
  assign sif.div  = s_r.ctrl[`DACS_CTRL_DIV_LO + 1:`DACS_CTRL_DIV_LO]; // R8

  assign prdata      = s_r.prdata;
  assign pready      = 1'b1;
  assign pslverr     = apb_access & ~addr_ok;
  assign busy        = s_r.busy;
  assign end_of_conv = s_r.eoc;
  assign data_out    = s_r.dout;

endmodule

/* verification/dacs_props.sv */
// Purpose: Port checker of the conversion sequencer
// Assumes: Mode bits shadowed from APB writes to CTRL
// Notes:   Shadow lags nothing, writes land at the access edge
`timescale 1ns/10ps
module dacs_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        busy,
  input wire logic        end_of_conv,
  input wire logic [15:0] data_out,
  input wire logic        ser_clk,
  input wire logic        frame_sync
);
  logic [6:0] ctl_r;
  logic [7:0] bcnt_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r  <= 7'h42;
      bcnt_r <= 8'h00;
    end else begin
      if (psel && penable && pwrite && paddr == 12'h000) begin
        ctl_r <= pwdata[6:0];
      end
      bcnt_r <= busy ? bcnt_r + 8'h01 : 8'h00;
    end
  end
  property p_busy_max; busy && !ctl_r[3] |-> bcnt_r < (ctl_r[2] ? 8'h14 : 8'h11); endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  property p_eoc_a; $rose(busy) |-> end_of_conv ##[1:12] !end_of_conv; endproperty
  a_eoc_a: assert property (p_eoc_a) else $error("channel A flag bad");
  property p_gap; $rose(end_of_conv) && !$rose(busy) |-> $past(busy) && $past(!end_of_conv); endproperty
  a_gap: assert property (p_gap) else $error("no flag gap");
  property p_eoc_b; $rose(end_of_conv) && !$rose(busy) |-> ##[1:7] !end_of_conv; endproperty
  a_eoc_b: assert property (p_eoc_b) else $error("channel B flag long");
  property p_busy_end; $fell(busy) |-> $past(!end_of_conv); endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy fell early");
  property p_lead; $fell(busy) && !ctl_r[0] |-> $stable(data_out); endproperty
  a_lead: assert property (p_lead) else $error("data late");
  property p_sck; $rose(ser_clk) |-> $past(!ser_clk) && (ctl_r[5:4] != 2'b11 || !$past(ser_clk, 2)); endproperty
  a_sck: assert property (p_sck) else $error("serial clock fast");
  property p_fs_lead; $rose(frame_sync) |-> !ser_clk ##1 !ser_clk; endproperty
  a_fs_lead: assert property (p_fs_lead) else $error("frame lead short");
  property p_fs_dc; $rose(busy) && ctl_r[0] && !ctl_r[3] |-> ##[3:7] $rose(frame_sync); endproperty
  a_fs_dc: assert property (p_fs_dc) else $error("frame not during");
  property p_fs_ac; $rose(busy) && ctl_r[0] && ctl_r[3] |-> ##[8:16] $rose(frame_sync); endproperty
  a_fs_ac: assert property (p_fs_ac) else $error("frame not after");
  property p_fs_busy; $fell(frame_sync) && ctl_r[3] |-> busy ##1 !busy; endproperty
  a_fs_busy: assert property (p_fs_busy) else $error("busy after frame");
  property p_port; ctl_r[0] ? ($past(ctl_r[0]) -> data_out == 16'h0000) : !frame_sync; endproperty
  a_port: assert property (p_port) else $error("port select");
endmodule
bind dacs_top dacs_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .busy, .end_of_conv, .data_out, .ser_clk, .frame_sync);

/* verification/dacs_host.sv */
// Purpose: Host model, pulses convert and captures frames
// Assumes: Data steady at serial clock rise
// Notes:   Keeps the last 32 bits shifted in
`timescale 1ns/10ps
module dacs_host (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic busy,
  input  wire logic frame_sync,
  input  wire logic ser_clk,
  input  wire logic serial_result_out,
  output logic      convert_start_n
);
  logic        sck_d_r;
  logic [31:0] cap_r;
  initial convert_start_n = 1'b1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_d_r <= 1'b0;
      cap_r   <= 32'h0;
    end else begin
      sck_d_r <= ser_clk;
      if (frame_sync && ser_clk && !sck_d_r) begin
        cap_r <= {cap_r[30:0], serial_result_out};
      end
    end
  end
  // Long low so the filtered synchroniser sees it
  task pulse();
    integer n;
    n = 0;
    while ((busy !== 1'b0 || frame_sync !== 1'b0) && n < 500) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    convert_start_n <= 1'b0;
    repeat (5) @(posedge pclk);
    convert_start_n <= 1'b1;
  endtask
endmodule

/* verification/dacs_top_tb.sv */
// Purpose: Self-checking bench of the conversion sequencer
// Assumes: Zero wait APB, results held constant
// Notes:   Serial limits of long frames left unchecked
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin num_checks++; if ((ex) !== (gt)) begin fails++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, gt); end end
module dacs_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        cs_n, busy, eoc, sck, fs, sdo, e;
  logic [15:0] ra, rb, dout;
  integer      fails, num_checks, bcur, blast;
  dacs_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .convert_start_n(cs_n), .adc_result_a(ra), .adc_result_b(rb), .busy(busy), .end_of_conv(eoc),
    .data_out(dout), .ser_clk(sck), .frame_sync(fs), .serial_result_out(sdo));
  dacs_host host (.pclk(pclk), .presetn(presetn), .busy(busy), .frame_sync(fs), .ser_clk(sck),
    .serial_result_out(sdo), .convert_start_n(cs_n));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (busy === 1'b1) bcur <= bcur + 1;
    else begin
      if (bcur != 0) blast <= bcur;
      bcur <= 0;
    end
  end
  task final_report();
    $display("checks %0d errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Waits on busy then frame so both serial timings finish
  task run(input logic [6:0] c, input logic [31:0] ew, input logic [15:0] ed);
    integer n;
    apb(1'b1, 12'h000, {25'h0, c});
    host.pulse();
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    `CHK("busy rise", 1'b1, busy)
    n = 0;
    while ((busy === 1'b1 || fs === 1'b1) && n < 400) begin
      @(posedge pclk);
      n++;
    end
    `CHK("busy end", 1'b1, n < 400)
    @(posedge pclk);
    if (!c[3]) `CHK("busy width", blast <= (c[2] ? 20 : 17), 1'b1)
    `CHK("data_out", ed, dout)
    if (c[0]) `CHK("frame word", ew, host.cap_r)
    apb(1'b0, 12'h008, 32'h0);
    `CHK("result", {ra, rb}, q)
  endtask
  initial begin
    fails = 0; num_checks = 0; bcur = 0; blast = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; ra = 16'hc3a5; rb = 16'h5a3c;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    `CHK("ctrl reset", 32'h00000042, q)
    apb(1'b0, 12'h004, 32'h0);
    `CHK("status idle", 32'h00000220, q)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("unmapped err", 1'b1, e)
    run(7'h42, 32'h0, ra);
    run(7'h04, 32'h0, rb);
    run(7'h0b, {ra, rb}, 16'h0000);
    run(7'h19, {rb, ra}, 16'h0000);
    run(7'h23, {ra, rb}, 16'h0000);
    run(7'h35, {rb, ra}, 16'h0000);
    final_report();
  end
  initial begin
    #(20000 * 100);
    fails++;
    final_report();
  end
endmodule
